// ==== shared/core_sfr_cfg.svh ====
/*
 * Offsets, field positions, reset values and enable mask of the core
 * special-function register group.
 * Assumes inclusion by bare name from any design or bench file.
 */
`ifndef CORE_SFR_CFG_SVH
`define CORE_SFR_CFG_SVH

`define ADDR_STATUS 9'h003
`define ADDR_INTCTL 9'h00B
`define ADDR_OPTIONS 9'h081
`define ADDR_PERIPH_EN 9'h08C

`define ST_INDIRECT_BANK 7
`define ST_BANK_HI 6
`define ST_BANK_LO 5
`define ST_WDT_TIMEOUT_N 4
`define ST_POWERDOWN_N 3
`define ST_ZERO 2
`define ST_NIBBLE 1
`define ST_CARRY 0

`define OPT_PULLUP_DIS 7
`define OPT_EXT_EDGE 6
`define OPT_T0_SOURCE 5
`define OPT_T0_EDGE 4
`define OPT_PRESC_ASSIGN 3

`define IC_GLOBAL 7
`define IC_PERIPH 6
`define IC_T0_EN 5
`define IC_EXT_EN 4
`define IC_PORT_EN 3
`define IC_T0_FLAG 2
`define IC_EXT_FLAG 1
`define IC_PORT_FLAG 0

`define PE_UNIMPL 3

`define RST_STATUS 8'h18
`define RST_OPTIONS 8'hFF
`define RST_INTCTL 8'h00
`define RST_PERIPH_EN 8'h00
`define PERIPH_EN_MASK 8'hF7

`endif

// ==== shared/core_sfr_pkg.sv ====
/*
 * Types shared by the core special-function register group.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package core_sfr_pkg;

    typedef enum logic [1:0] {
        ALU_NONE = 2'h0,
        ALU_ADD = 2'h1,
        ALU_SUB = 2'h3,
        ALU_LOGIC = 2'h2
    } alu_kind_t;

    typedef enum logic [1:0] {
        ROT_NONE = 2'h0,
        ROT_LEFT = 2'h1,
        ROT_RIGHT = 2'h3
    } rot_kind_t;

endpackage : core_sfr_pkg

// ==== verilog/pin_sync_edge.sv ====
/*
 * Three-stage pin synchroniser with rise and fall detection.
 * Assumes the pin is asynchronous to i_mclk.
 */
`timescale 1ns/1ps
module pin_sync_edge
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Pin and results.
    input wire logic i_pin,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            s1 <= 1'h0;
            s2 <= 1'h0;
            s3 <= 1'h0;
        end
        else
        begin
            s1 <= i_pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A change counts once the last two stages agree on the new level.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_level <= 1'h0;
        else if (s2 == s3)
            o_level <= s3;
    end

    assign o_rise = (s2 == s3) && s3 && !o_level;
    assign o_fall = (s2 == s3) && !s3 && o_level;
endmodule : pin_sync_edge

// ==== verilog/core_sfr_regs.sv ====
/*
 * Core special-function registers: result flags, bank selects, reset
 * status, timer0 and watchdog prescaler, interrupt control and
 * peripheral interrupt enables, with timer0 and pin event detection.
 * Assumes the core drives one access strobe at a time and that the
 * peripheral flag vector comes from logic on i_mclk.
 */
// Function
// - Indirect bank bit picks upper bank pair when set, lower when clear.
// - Two direct bank bits select banks zero to three.
// - Timeout bit set at power-up, watchdog clear, sleep; cleared on timeout.
// - Power-down bit set at power-up or watchdog clear; cleared by sleep.
// - Register writes to timeout and power-down bits are ignored.
// - Flag-updating instruction writing status keeps flag logic results.
// - Zero flag follows whether the operation result is zero.
// - Nibble carry from bit three; inverted borrow when subtracting.
// - Carry out of bit seven; subtraction adds two's complement.
// - Rotates load carry with the bit shifted out.
// - Pull-up disable bit kills pull-ups; else each follows its latch.
// - External pin edge select: rising when set, falling when clear.
// - Timer0 source: external pin when set, instruction clock when clear.
// - External timer0 edge: falling when set, rising when clear.
// - Prescaler goes to watchdog when set, timer0 otherwise; timer0 1:1.
// - Timer0 divides by 2^(code+1), watchdog by 2^code.
// - Flags set on their condition regardless of any enable.
// - Global enable gates all; peripheral enable gates peripheral sources.
// - Separate enables for timer0, external pin and port change.
// - Timer0 overflow flag sets on overflow, stays until cleared.
// - External pin flag sets on selected edge, stays until cleared.
// - Port change flag sets when upper port B pins change.
// - Peripheral enable register bits, bit three reads zero.
`timescale 1ns/1ps
`include "core_sfr_cfg.svh"
module core_sfr_regs
#(
    parameter int PRESC_W = 8
)
(
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Register port.
    input wire logic [8:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Instruction execution results.
    input wire logic i_instr_tick,
    input wire core_sfr_pkg::alu_kind_t i_alu_kind,
    input wire core_sfr_pkg::rot_kind_t i_rot_kind,
    input wire logic [7:0] i_op_a,
    input wire logic [7:0] i_op_b,
    input wire logic [7:0] i_result,
    input wire logic i_watchdog_clear_instruction,
    input wire logic i_sleep_instruction,
    input wire logic i_watchdog_timeout,
    // Addressing.
    input wire logic [7:0] i_fsr,
    input wire logic [6:0] i_direct_offset,
    output logic [8:0] o_indirect_addr,
    output logic [8:0] o_direct_addr,
    // Pins and peripherals.
    input wire logic i_external_interrupt_pin,
    input wire logic i_timer0_external_clock_pin,
    input wire logic [3:0] i_portb_high_pins,
    input wire logic [7:0] i_portb_latch,
    input wire logic [7:0] i_periph_flags,
    output logic [7:0] o_portb_pullup_en,
    output logic [7:0] o_timer0_count,
    output logic o_watchdog_tick,
    output logic o_int_request
);
    logic [7:0] status;
    logic [7:0] options;
    logic [7:0] intctl;
    logic [7:0] periph_en;
    logic [7:0] timer0_count;
    logic [PRESC_W-1:0] presc;
    logic ext_level;
    logic ext_rise;
    logic ext_fall;
    logic t0_rise;
    logic t0_fall;
    logic t0_level;
    logic [3:0] port_lvl;
    logic [3:0] port_rise;
    logic [3:0] port_fall;
    logic wr_status;
    logic wr_intctl;
    logic flag_update;
    logic t0_source_tick;
    logic presc_tap;
    logic t0_inc;
    logic t0_overflow;
    logic ext_event;
    logic port_event;
    logic [4:0] nib_sum;
    logic [8:0] full_sum;
    logic [7:0] addend;
    logic next_zero;
    logic next_nibble;
    logic next_carry;
    logic [2:0] rate;

    pin_sync_edge u_ext
    (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_pin(i_external_interrupt_pin),
        .o_level(ext_level),
        .o_rise(ext_rise),
        .o_fall(ext_fall)
    );

    pin_sync_edge u_t0
    (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_pin(i_timer0_external_clock_pin),
        .o_level(t0_level),
        .o_rise(t0_rise),
        .o_fall(t0_fall)
    );

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_port
            pin_sync_edge u_port
            (
                .i_mclk(i_mclk),
                .i_reset_n(i_reset_n),
                .i_pin(i_portb_high_pins[g]),
                .o_level(port_lvl[g]),
                .o_rise(port_rise[g]),
                .o_fall(port_fall[g])
            );
        end
    endgenerate

    assign wr_status = i_wr && (i_addr == `ADDR_STATUS);
    assign wr_intctl = i_wr && (i_addr == `ADDR_INTCTL);
    assign flag_update = i_instr_tick
        && (i_alu_kind != core_sfr_pkg::ALU_NONE);
    assign rate = options[2:0];

    // Subtraction adds the inverted operand plus one: carry means no borrow.
    assign addend = (i_alu_kind == core_sfr_pkg::ALU_SUB)
        ? ~i_op_b : i_op_b;
    assign full_sum = {1'h0, i_op_a} + {1'h0, addend}
        + {8'h00, (i_alu_kind == core_sfr_pkg::ALU_SUB)};
    assign nib_sum = {1'h0, i_op_a[3:0]} + {1'h0, addend[3:0]}
        + {4'h0, (i_alu_kind == core_sfr_pkg::ALU_SUB)};

    always_comb
    begin
        next_zero = status[`ST_ZERO];
        next_nibble = status[`ST_NIBBLE];
        next_carry = status[`ST_CARRY];
        if (flag_update)
            next_zero = (i_result == 8'h00);
        if (i_instr_tick && i_alu_kind[0])
        begin
            next_nibble = nib_sum[4];
            next_carry = full_sum[8];
        end
        if (i_instr_tick && (i_rot_kind == core_sfr_pkg::ROT_LEFT))
            next_carry = i_op_a[7];
        else if (i_instr_tick && (i_rot_kind == core_sfr_pkg::ROT_RIGHT))
            next_carry = i_op_a[0];
    end

    // Result flags: instruction logic beats a data write to the same bits.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            status[2:0] <= 3'(`RST_STATUS);
        else if (flag_update || (i_instr_tick
            && (i_rot_kind != core_sfr_pkg::ROT_NONE)))
            status[2:0] <= {next_zero, next_nibble, next_carry};
        else if (wr_status)
            status[2:0] <= i_wdata[2:0];
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            status[7:5] <= 3'(`RST_STATUS >> 5);
        else if (wr_status)
            status[7:5] <= i_wdata[7:5];
    end

    // Reset status bits ignore writes; a timeout wins over a clear.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            status[`ST_WDT_TIMEOUT_N] <= 1'h1;
            status[`ST_POWERDOWN_N] <= 1'h1;
        end
        else
        begin
            if (i_watchdog_timeout)
                status[`ST_WDT_TIMEOUT_N] <= 1'h0;
            else if (i_watchdog_clear_instruction || i_sleep_instruction)
                status[`ST_WDT_TIMEOUT_N] <= 1'h1;
            if (i_sleep_instruction)
                status[`ST_POWERDOWN_N] <= 1'h0;
            else if (i_watchdog_clear_instruction)
                status[`ST_POWERDOWN_N] <= 1'h1;
        end
    end

    assign o_indirect_addr = {status[`ST_INDIRECT_BANK], i_fsr};
    assign o_direct_addr = {status[6:5], i_direct_offset};

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            options <= `RST_OPTIONS;
        else if (i_wr && (i_addr == `ADDR_OPTIONS))
            options <= i_wdata;
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            periph_en <= `RST_PERIPH_EN;
        else if (i_wr && (i_addr == `ADDR_PERIPH_EN))
            periph_en <= i_wdata & `PERIPH_EN_MASK;
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_portb_pullup_en <= 8'h00;
        else if (options[`OPT_PULLUP_DIS])
            o_portb_pullup_en <= 8'h00;
        else
            o_portb_pullup_en <= i_portb_latch;
    end

    // Timer0 source and edge choice.
    assign t0_source_tick = options[`OPT_T0_SOURCE]
        ? (options[`OPT_T0_EDGE] ? t0_fall : t0_rise)
        : i_instr_tick;

    // One shared ripple prescaler; a tap bit falling marks one output count.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            presc <= '0;
        else if (options[`OPT_PRESC_ASSIGN] ? i_instr_tick : t0_source_tick)
            presc <= presc + 1'b1;
    end

    // Timer0 takes 2^(code+1), the watchdog 2^code with code 000 as 1:1.
    always_comb
    begin
        presc_tap = 1'h0;
        o_watchdog_tick = 1'h0;
        if (options[`OPT_PRESC_ASSIGN])
        begin
            o_watchdog_tick = i_instr_tick
                && ((presc & ((PRESC_W'(1) << rate) - PRESC_W'(1)))
                == ((PRESC_W'(1) << rate) - PRESC_W'(1)));
        end
        else
        begin
            presc_tap = t0_source_tick
                && ((presc & ((PRESC_W'(2) << rate) - PRESC_W'(1)))
                == ((PRESC_W'(2) << rate) - PRESC_W'(1)));
        end
    end

    assign t0_inc = options[`OPT_PRESC_ASSIGN]
        ? t0_source_tick : presc_tap;
    assign t0_overflow = t0_inc && (timer0_count == 8'hFF);

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            timer0_count <= 8'h00;
        else if (t0_inc)
            timer0_count <= timer0_count + 8'h01;
    end
    assign o_timer0_count = timer0_count;

    assign ext_event = options[`OPT_EXT_EDGE] ? ext_rise : ext_fall;

    // Every synchronised change counts, so pins moving one cycle apart
    // are never lost.
    assign port_event = |(port_rise | port_fall);

    // Enables from software; flags set by events win over a software clear.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            intctl <= `RST_INTCTL;
        else
        begin
            if (wr_intctl)
                intctl <= i_wdata;
            if (t0_overflow)
                intctl[`IC_T0_FLAG] <= 1'h1;
            if (ext_event)
                intctl[`IC_EXT_FLAG] <= 1'h1;
            if (port_event)
                intctl[`IC_PORT_FLAG] <= 1'h1;
        end
    end

    always_comb
    begin
        o_int_request = intctl[`IC_GLOBAL]
            && ((|(intctl[5:3] & intctl[2:0]))
            || (intctl[`IC_PERIPH] && |(periph_en & i_periph_flags)));
    end

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_rdata <= 8'h00;
        else if (i_rd)
        begin
            unique case (i_addr)
                `ADDR_STATUS: o_rdata <= status;
                `ADDR_INTCTL: o_rdata <= intctl;
                `ADDR_OPTIONS: o_rdata <= options;
                `ADDR_PERIPH_EN: o_rdata <= periph_en;
                default: o_rdata <= 8'h00;
            endcase
        end
        else
            o_rdata <= 8'h00;
    end
endmodule : core_sfr_regs

// ==== sim/core_sfr_regs_assertions.sv ====
/* Checker for the core register group, bound to core_sfr_regs.
   Assumes only software writes change the enable and bank bits. */
`timescale 1ns/1ps
`include "core_sfr_cfg.svh"
module core_sfr_regs_chk
#(
    parameter int PRESC_W = 8
)
(
    // Clock, reset and register port.
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [8:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Addressing, pins and results.
    input wire logic [7:0] i_fsr,
    input wire logic [6:0] i_direct_offset,
    input wire logic [8:0] o_indirect_addr,
    input wire logic [8:0] o_direct_addr,
    input wire logic [7:0] i_portb_latch,
    input wire logic [7:0] i_periph_flags,
    input wire logic [7:0] o_portb_pullup_en,
    input wire logic [7:0] o_timer0_count,
    input wire logic o_int_request
);
    logic [7:0] opt_sh;
    logic [7:0] pe_sh;
    logic [7:0] ic_sh;
    logic [2:0] bank_sh;
    // Hardware never touches the option, enable and bank bits, so a write shadow predicts them.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            opt_sh <= `RST_OPTIONS;
            pe_sh <= `RST_PERIPH_EN;
            ic_sh <= `RST_INTCTL;
            bank_sh <= 3'h0;
        end
        else if (i_wr)
        begin
            if (i_addr == `ADDR_OPTIONS) opt_sh <= i_wdata;
            if (i_addr == `ADDR_PERIPH_EN) pe_sh <= i_wdata;
            if (i_addr == `ADDR_INTCTL) ic_sh <= i_wdata;
            if (i_addr == `ADDR_STATUS) bank_sh <= i_wdata[7:5];
        end
    end
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);
    property p_indirect;
        o_indirect_addr == {bank_sh[2], i_fsr};
    endproperty
    a_indirect: assert property (p_indirect)
        else $error("indirect address mismatch");
    property p_direct;
        o_direct_addr == {bank_sh[1:0], i_direct_offset};
    endproperty
    a_direct: assert property (p_direct)
        else $error("direct address mismatch");
    property p_bank_read;
        $past(i_rd && i_addr == `ADDR_STATUS)
            |-> o_rdata[7:5] == $past(bank_sh);
    endproperty
    a_bank_read: assert property (p_bank_read)
        else $error("bank bits read back wrong");
    property p_pullup;
        o_portb_pullup_en == ($past(opt_sh[7]) ? 8'h00 : $past(i_portb_latch));
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up enables wrong");
    property p_options;
        $past(i_rd && i_addr == `ADDR_OPTIONS) |-> o_rdata == $past(opt_sh);
    endproperty
    a_options: assert property (p_options)
        else $error("option register read back wrong");
    property p_periph;
        $past(i_rd && i_addr == `ADDR_PERIPH_EN)
            |-> o_rdata == ($past(pe_sh) & `PERIPH_EN_MASK);
    endproperty
    a_periph: assert property (p_periph)
        else $error("peripheral enables read back wrong");
    property p_gie;
        !ic_sh[7] |-> !o_int_request;
    endproperty
    a_gie: assert property (p_gie)
        else $error("request while globally disabled");
    property p_periph_req;
        ic_sh[7] && ic_sh[6] && |(i_periph_flags & pe_sh & `PERIPH_EN_MASK)
            |-> o_int_request;
    endproperty
    a_periph_req: assert property (p_periph_req)
        else $error("peripheral request missing");
    property p_timer;
        8'(o_timer0_count - $past(o_timer0_count)) <= 8'h01;
    endproperty
    a_timer: assert property (p_timer)
        else $error("timer0 jumped");
endmodule : core_sfr_regs_chk
bind core_sfr_regs core_sfr_regs_chk #(.PRESC_W(PRESC_W)) i_core_sfr_regs_chk
(
    .i_mclk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_fsr, .i_direct_offset, .o_indirect_addr, .o_direct_addr,
    .i_portb_latch, .i_periph_flags, .o_portb_pullup_en,
    .o_timer0_count, .o_int_request
);

// ==== sim/tmr_clk_src.sv ====
/* Timer0 clock pin source: makes a requested number of pin toggles.
   Assumes one request at a time, started by a one-cycle i_go. */
`timescale 1ns/1ps
module tmr_clk_src
(
    // Clock, reset and request.
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_go,
    input wire logic [9:0] i_n,
    // Pin and state.
    output logic o_pin,
    output logic o_busy
);
    logic [9:0] left;
    logic [2:0] hold;
    assign o_busy = (left != 10'h000);
    // Eight cycles per level outlast the synchroniser, so no edge is lost.
    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            left <= 10'h000;
            hold <= 3'h0;
            o_pin <= 1'h0;
        end
        else if (i_go)
        begin
            left <= i_n;
            hold <= 3'h0;
        end
        else if (o_busy)
        begin
            hold <= hold + 3'h1;
            if (hold == 3'h7)
            begin
                o_pin <= ~o_pin;
                left <= left - 10'h001;
            end
        end
    end
endmodule : tmr_clk_src

// ==== sim/core_status_option_interrupt_regs_tb.sv ====
/* Register-level testbench of the core register group.
   Assumes the pin source model drives the timer0 clock pin. */
`timescale 1ns/1ps
`include "core_sfr_cfg.svh"
module core_status_option_interrupt_regs_tb;
    logic mclk, rst_n, wr, rd, tick, wclr, slp, wto, ext, go, pin, busy;
    logic irq, wtick;
    logic [8:0] addr, iaddr, daddr;
    logic [7:0] wdata, rdata, op_a, op_b, res, fsr, latch, pflags, pull;
    logic [7:0] t0cnt, c;
    logic [6:0] doff;
    logic [3:0] pbh;
    logic [9:0] tn_req;
    core_sfr_pkg::alu_kind_t alu;
    core_sfr_pkg::rot_kind_t rot;
    int errors, n_compared, cycles, wdt_n;
    logic [1:0] ak [6] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h0, 2'h3};
    logic [1:0] rk [6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h3, 2'h0};
    logic [7:0] oa [6] = '{8'h0F, 8'hFF, 8'h00, 8'h01, 8'h01, 8'h05};
    logic [7:0] ob [6] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h05};
    logic [7:0] rs [6] = '{8'h10, 8'h00, 8'h5A, 8'h02, 8'h00, 8'h00};
    logic [2:0] ex [6] = '{3'h2, 3'h7, 3'h3, 3'h2, 3'h3, 3'h7};
    logic [2:0] ev [3] = '{3'h1, 3'h2, 3'h1};
    logic [7:0] px [3] = '{8'h08, 8'h10, 8'h00};
    logic [7:0] topt [4] = '{8'h28, 8'h38, 8'h20, 8'h08};
    logic [9:0] tn [4] = '{10'h003, 10'h003, 10'h010, 10'h004};
    logic [7:0] td [4] = '{8'h02, 8'h02, 8'h04, 8'h00};
    logic [7:0] ic [8] = '{8'h89, 8'h81, 8'h09, 8'hA4,
        8'h92, 8'hC0, 8'h80, 8'hC0};
    logic [7:0] ip [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h01, 8'h01, 8'h08};
    logic ix [8] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0};
    core_sfr_regs i_core_sfr_regs
    (
        .i_mclk(mclk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_instr_tick(tick),
        .i_alu_kind(alu), .i_rot_kind(rot), .i_op_a(op_a), .i_op_b(op_b),
        .i_result(res), .i_watchdog_clear_instruction(wclr),
        .i_sleep_instruction(slp), .i_watchdog_timeout(wto),
        .i_fsr(fsr), .i_direct_offset(doff), .o_indirect_addr(iaddr),
        .o_direct_addr(daddr), .i_external_interrupt_pin(ext),
        .i_timer0_external_clock_pin(pin), .i_portb_high_pins(pbh),
        .i_portb_latch(latch), .i_periph_flags(pflags),
        .o_portb_pullup_en(pull), .o_timer0_count(t0cnt),
        .o_watchdog_tick(wtick), .o_int_request(irq)
    );
    tmr_clk_src i_tmr_clk_src
    (
        .i_mclk(mclk), .i_reset_n(rst_n), .i_go(go), .i_n(tn_req),
        .o_pin(pin), .o_busy(busy)
    );
    initial
    begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end
    task stop_test();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    // The ceiling leaves a wide margin over the longest expected run.
    always @(posedge mclk)
    begin
        cycles++;
        if (wtick)
            wdt_n++;
        if (cycles == 20000)
        begin
            errors++;
            stop_test();
        end
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wt
    task wr_reg(input logic [8:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge mclk);
        wr <= 1'h0;
    endtask : wr_reg
    task rd_reg(input logic [8:0] a, input logic [7:0] m, e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'h1;
        @(posedge mclk);
        rd <= 1'h0;
        #1 chk(rdata & m, e);
    endtask : rd_reg
    task ins(input logic [1:0] k, r, input logic [7:0] a, b, s,
        input logic w, input logic [7:0] d);
        @(posedge mclk);
        {tick, wr, addr, wdata} <= {1'h1, w, `ADDR_STATUS, d};
        alu <= core_sfr_pkg::alu_kind_t'(k);
        rot <= core_sfr_pkg::rot_kind_t'(r);
        {op_a, op_b, res} <= {a, b, s};
        @(posedge mclk);
        {tick, wr} <= 2'h0;
        alu <= core_sfr_pkg::ALU_NONE;
        rot <= core_sfr_pkg::ROT_NONE;
    endtask : ins
    task evt(input logic [2:0] e);
        @(posedge mclk);
        {tick, wclr, slp, wto} <= {1'h1, e};
        @(posedge mclk);
        {tick, wclr, slp, wto} <= 4'h0;
    endtask : evt
    task tg(input logic [9:0] n);
        @(posedge mclk);
        go <= 1'h1;
        tn_req <= n;
        @(posedge mclk);
        go <= 1'h0;
        #1;
        while (busy) @(posedge mclk);
        wt(8);
    endtask : tg
    initial
    begin
        rst_n = 1'h0;
        {wr, rd, tick, wclr, slp, wto, ext, go} = 8'h00;
        {addr, wdata, op_a, op_b, res} = 41'h0;
        {latch, pflags, pbh, tn_req} = 30'h0;
        fsr = 8'hA5;
        doff = 7'h5A;
        alu = core_sfr_pkg::ALU_NONE;
        rot = core_sfr_pkg::ROT_NONE;
        errors = 0;
        n_compared = 0;
        cycles = 0;
        wdt_n = 0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'h1;
        rd_reg(`ADDR_STATUS, 8'hF8, `RST_STATUS);
        rd_reg(`ADDR_OPTIONS, 8'hFF, `RST_OPTIONS);
        rd_reg(`ADDR_INTCTL, 8'hFF, `RST_INTCTL);
        rd_reg(`ADDR_PERIPH_EN, 8'hFF, `RST_PERIPH_EN);
        rd_reg(9'h004, 8'hFF, 8'h00);
        wr_reg(`ADDR_STATUS, 8'h00);
        rd_reg(`ADDR_STATUS, 8'hFF, 8'h18);
        wr_reg(`ADDR_PERIPH_EN, 8'hFF);
        rd_reg(`ADDR_PERIPH_EN, 8'hFF, 8'hF7);
        for (int i = 0; i < 6; i++)
        begin
            ins(ak[i], rk[i], oa[i], ob[i], rs[i], 1'h0, 8'h00);
            rd_reg(`ADDR_STATUS, 8'h07, {5'h00, ex[i]});
        end
        ins(2'h1, 2'h0, 8'h0F, 8'h01, 8'h10, 1'h1, 8'hA0);
        rd_reg(`ADDR_STATUS, 8'hFF, 8'hBA);
        for (int i = 0; i < 3; i++)
        begin
            evt(ev[i]);
            rd_reg(`ADDR_STATUS, 8'h18, px[i]);
        end
        wr_reg(`ADDR_STATUS, 8'hBF);
        rd_reg(`ADDR_STATUS, 8'h18, 8'h00);
        evt(3'h4);
        rd_reg(`ADDR_STATUS, 8'h18, 8'h18);
        @(posedge mclk) latch <= 8'h96;
        wr_reg(`ADDR_OPTIONS, 8'h48);
        wt(2);
        chk(pull, 8'h96);
        wr_reg(`ADDR_OPTIONS, 8'hC8);
        wt(2);
        chk(pull, 8'h00);
        wr_reg(`ADDR_INTCTL, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            if (i == 2) wr_reg(`ADDR_OPTIONS, 8'h08);
            @(posedge mclk) ext <= ~ext;
            wt(6);
            rd_reg(`ADDR_INTCTL, 8'h02,
                (ext == (i < 2)) ? 8'h02 : 8'h00);
            wr_reg(`ADDR_INTCTL, 8'h00);
        end
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk) pbh[i] <= ~pbh[i];
            wt(6);
            rd_reg(`ADDR_INTCTL, 8'h01, 8'h01);
            wr_reg(`ADDR_INTCTL, 8'h00);
            rd_reg(`ADDR_INTCTL, 8'h01, 8'h00);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(`ADDR_OPTIONS, topt[i]);
            #1 c = t0cnt;
            tg(tn[i]);
            chk(t0cnt - c, td[i]);
        end
        wr_reg(`ADDR_OPTIONS, 8'h28);
        wr_reg(`ADDR_INTCTL, 8'h00);
        #1 tg(10'(2 * (9'h100 - t0cnt)));
        chk(t0cnt, 8'h00);
        rd_reg(`ADDR_INTCTL, 8'h04, 8'h04);
        wr_reg(`ADDR_OPTIONS, 8'h0A);
        #1 c = t0cnt;
        wdt_n = 0;
        for (int i = 0; i < 16; i++)
            evt(3'h0);
        wt(1);
        chk(t0cnt - c, 8'h10);
        chk(8'(wdt_n), 8'h04);
        @(posedge mclk) pflags <= 8'hFF;
        wr_reg(`ADDR_INTCTL, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            wr_reg(`ADDR_PERIPH_EN, ip[i]);
            wr_reg(`ADDR_INTCTL, ic[i]);
            wt(1);
            chk({7'h00, irq}, {7'h00, ix[i]});
        end
        stop_test();
    end
endmodule : core_status_option_interrupt_regs_tb
